// ===== verilog/bcto_pkg.sv
`default_nettype none
// shared constants for the bus cycle timeout timer
package bcto_pkg;

  // host i/o offsets (byte wide, write only)
  localparam logic [7:0] BCTO_ADDR_COUNT_PORT = 8'h14;
  localparam logic [7:0] BCTO_ADDR_SETUP_CTRL = 8'h16;

  // setup control field layout
  localparam int         BCTO_SEL_LSB  = 6;
  localparam int         BCTO_SEL_W    = 2;
  localparam int         BCTO_MODE_W   = 6;
  localparam logic [1:0] BCTO_SEL_SLAVE  = 2'h0;
  localparam logic [1:0] BCTO_SEL_MASTER = 2'h1;
  localparam logic [1:0] BCTO_SEL_SYSCTL = 2'h2;
  localparam logic [5:0] BCTO_MODE_PATTERN = 6'h34;

  // reset values
  localparam logic [15:0] BCTO_COUNT_RST = 16'h0000;
  localparam logic [7:0]  BCTO_BYTE_RST  = 8'h00;
  localparam logic [1:0]  BCTO_SEL_RST   = 2'h0;

  // timing: one count step of 800 ns at a 125 MHz clock
  localparam int BCTO_CLK_HZ       = 125_000_000;
  localparam int BCTO_TICK_HZ      = 1_250_000;
  localparam int BCTO_STEP_NS      = 800;
  localparam int BCTO_CLK_PERIOD_PS = 1_000_000_000 / (BCTO_CLK_HZ / 1000);
  localparam int BCTO_STEP_CYCLES  = (BCTO_STEP_NS * 1000) / BCTO_CLK_PERIOD_PS;
  localparam int BCTO_DIV_W        = 7;

  // a loaded count of zero means the full 16-bit range
  localparam logic [16:0] BCTO_FULL_SPAN = 17'h10000;

  // load sequencer, gray coded along idle -> low -> high
  typedef enum logic [1:0] {
    BCTO_LD_IDLE = 2'b00,
    BCTO_LD_LOW  = 2'b01,
    BCTO_LD_HIGH = 2'b11
  } bcto_load_e;

endpackage
`default_nettype wire

// ===== verilog/bcto_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the tick restart and the 800 ns tick between timer and divider
interface bcto_tick_if;
  logic restart;
  logic tick;
  modport ctrl (output restart, input tick);
  modport div  (input restart, output tick);
endinterface
`default_nettype wire

// ===== verilog/bcto_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
// divides the reference clock down to one tick enable every 800 ns
module bcto_tick_div (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // tick link to the timer
  bcto_tick_if.div  tk
);

  localparam logic [bcto_pkg::BCTO_DIV_W-1:0] DIV_LAST =
    bcto_pkg::BCTO_DIV_W'(bcto_pkg::BCTO_STEP_CYCLES - 1);
  localparam int DIV_M1 = bcto_pkg::BCTO_STEP_CYCLES - 1;

  logic [bcto_pkg::BCTO_DIV_W-1:0] div_q;
  logic [bcto_pkg::BCTO_DIV_W-1:0] gap_q;

  // divider restarts so the first step after a reload is a full one
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || tk.restart || div_q == DIV_LAST)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  assign tk.tick = (div_q == DIV_LAST) && !tk.restart;

  // helper: cycles since last tick or restart
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || tk.tick || tk.restart)
      gap_q <= '0;
    else
      gap_q <= gap_q + 1'b1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_tick_period: assert property (
    tk.tick |-> gap_q == DIV_M1)
    else $error("tick spacing is not one 800 ns step");
  a_tick_bound: assert property (
    gap_q <= DIV_M1)
    else $error("tick missing after a full step");

endmodule // bcto_tick_div
`default_nettype wire

// ===== verilog/bcto_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - overlong bus cycle ends with bus error
// - timeout acts only as system controller
// - two byte writes, low byte then high
// - limit is count times 800 ns
// - control bits 7-6 select slave/master/sysctl
// - count step is 1.25 MHz tick
module bcto_timer (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // host i/o port
  input  wire logic [7:0] i_io_addr,
  input  wire logic       i_io_wr_en,
  input  wire logic       i_io_rd_en,
  input  wire logic [7:0] i_io_wdata,
  output logic      [7:0] o_io_rdata,
  // expansion bus cycle tracking
  input  wire logic       i_sys_ctrl,
  input  wire logic       i_cycle_start,
  input  wire logic       i_cycle_done,
  // status
  output logic            o_bus_error,
  output logic            o_timeout_active,
  output logic            o_count_loaded,
  output logic      [1:0] o_timer_sel
);

  bcto_tick_if tick_link ();

  bcto_pkg::bcto_load_e load_q;
  logic [7:0]  low_byte_q;
  logic [15:0] count_q;
  logic        loaded_q;
  logic [1:0]  sel_q;
  logic [16:0] remain_q;
  logic        active_q;
  logic        error_q;
  logic [16:0] span;
  logic        ctrl_wr;
  logic        data_wr;
  logic        reload;
  logic        final_tick;
  logic [1:0]  wr_sel;

  // host write decode; reads are not decoded into any state
  assign ctrl_wr = i_io_wr_en && (i_io_addr == bcto_pkg::BCTO_ADDR_SETUP_CTRL);
  assign data_wr = i_io_wr_en && (i_io_addr == bcto_pkg::BCTO_ADDR_COUNT_PORT);
  assign wr_sel  = i_io_wdata[bcto_pkg::BCTO_SEL_LSB +: bcto_pkg::BCTO_SEL_W];

  // last timer selected by a control write
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      sel_q <= bcto_pkg::BCTO_SEL_RST;
    else if (ctrl_wr)
      sel_q <= wr_sel;
  end

  // byte sequencer: only a sysctl select arms the low/high pair
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      load_q <= bcto_pkg::BCTO_LD_IDLE;
    else if (ctrl_wr)
    begin
      if (wr_sel == bcto_pkg::BCTO_SEL_SYSCTL)
        load_q <= bcto_pkg::BCTO_LD_LOW;
      else
        load_q <= bcto_pkg::BCTO_LD_IDLE;
    end
    else if (data_wr)
    begin
      unique case (load_q)
        bcto_pkg::BCTO_LD_LOW:  load_q <= bcto_pkg::BCTO_LD_HIGH;
        bcto_pkg::BCTO_LD_HIGH: load_q <= bcto_pkg::BCTO_LD_IDLE;
        bcto_pkg::BCTO_LD_IDLE: load_q <= bcto_pkg::BCTO_LD_IDLE;
        default:                load_q <= bcto_pkg::BCTO_LD_IDLE;
      endcase
    end
  end

  // low byte holding register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      low_byte_q <= bcto_pkg::BCTO_BYTE_RST;
    else if (data_wr && load_q == bcto_pkg::BCTO_LD_LOW)
      low_byte_q <= i_io_wdata;
  end

  // count assembled high * 256 + low; invalid while a reload is pending
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      count_q  <= bcto_pkg::BCTO_COUNT_RST;
      loaded_q <= 1'b0;
    end
    else if (ctrl_wr && wr_sel == bcto_pkg::BCTO_SEL_SYSCTL)
      loaded_q <= 1'b0;
    else if (data_wr && load_q == bcto_pkg::BCTO_LD_HIGH)
    begin
      count_q  <= {i_io_wdata, low_byte_q};
      loaded_q <= 1'b1;
    end
  end

  // read data: write-only addresses answer with zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_io_rdata <= bcto_pkg::BCTO_BYTE_RST;
    else
      o_io_rdata <= bcto_pkg::BCTO_BYTE_RST;
  end

  // zero count runs the full range
  assign span = (count_q == bcto_pkg::BCTO_COUNT_RST)
              ? bcto_pkg::BCTO_FULL_SPAN : {1'b0, count_q};
  assign reload = i_cycle_start && i_sys_ctrl && loaded_q;
  assign tick_link.restart = reload;
  assign final_tick = active_q && tick_link.tick && remain_q == 17'h00001;

  // timeout counter: reload per cycle, count 800 ns steps
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      remain_q <= '0;
      active_q <= 1'b0;
    end
    else if (reload)
    begin
      remain_q <= span;
      active_q <= 1'b1;
    end
    else if (i_cycle_done || !i_sys_ctrl || final_tick)
      active_q <= 1'b0;
    else if (active_q && tick_link.tick)
      remain_q <= remain_q - 17'h00001;
  end

  // bus error pulse; a completion or a new start in the same cycle wins
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      error_q <= 1'b0;
    else
      error_q <= final_tick && i_sys_ctrl && !i_cycle_done
                 && !reload;
  end

  bcto_tick_div u_tick_div (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .tk        (tick_link)
  );

  assign o_bus_error      = error_q;
  assign o_timeout_active = active_q;
  assign o_count_loaded   = loaded_q;
  assign o_timer_sel      = sel_q;

  // helper: ticks seen since the last reload and the span it loaded
  logic [16:0] ticks_q;
  logic [16:0] armed_span_q;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      ticks_q      <= '0;
      armed_span_q <= '0;
    end
    else if (reload)
    begin
      ticks_q      <= '0;
      armed_span_q <= span;
    end
    else if (active_q && tick_link.tick)
      ticks_q <= ticks_q + 17'h00001;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_error_after_limit: assert property (
    o_bus_error |-> ticks_q == armed_span_q)
    else $error("bus error before the programmed limit");
  a_error_needs_run: assert property (
    o_bus_error |-> $past(active_q) && !active_q)
    else $error("bus error without a running timeout");
  a_no_sysctl_quiet: assert property (
    !i_sys_ctrl |=> !active_q && !o_bus_error)
    else $error("timeout acts outside system controller mode");
  a_byte_order: assert property (
    data_wr && load_q == bcto_pkg::BCTO_LD_LOW && !ctrl_wr ##1
    data_wr && load_q == bcto_pkg::BCTO_LD_HIGH && !ctrl_wr
    |=> count_q == {$past(i_io_wdata), $past(i_io_wdata, 2)} && loaded_q)
    else $error("count not assembled low byte first");
  a_select_decode: assert property (
    ctrl_wr |=> (load_q == bcto_pkg::BCTO_LD_LOW) ==
                ($past(wr_sel) == bcto_pkg::BCTO_SEL_SYSCTL))
    else $error("timer select field misdecoded");
  a_reload_start: assert property (
    reload |=> active_q && remain_q == $past(span))
    else $error("cycle start did not reload the count");
  a_done_stops: assert property (
    i_cycle_done && !reload |=> !active_q ##1 !o_bus_error)
    else $error("completed cycle still timed or flagged");
  a_read_inert: assert property (
    i_io_rd_en && !i_io_wr_en
    |=> load_q == $past(load_q) && o_io_rdata == 8'h00)
    else $error("read disturbed the byte sequence");

  c_timeout: cover property (reload ##[1:1000] o_bus_error);
  c_clean_done: cover property (active_q ##1 i_cycle_done ##1 !active_q);
  c_count_load: cover property (ctrl_wr ##[1:8] data_wr ##[1:8] data_wr);

endmodule // bcto_timer
`default_nettype wire

// ===== bench/bcto_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far-side bus model: opens a cycle, completes it late or never
module bcto_bus_partner (
  // clock
  input  wire logic i_ref_clk,
  // cycle handshake toward the timer
  output logic      o_cycle_start,
  output logic      o_cycle_done
);
  initial o_cycle_start = 1'b0;
  initial o_cycle_done = 1'b0;

  // start pulse, then a done pulse after wait_cyc cycles unless hung
  task automatic run(input int wait_cyc, input bit hang);
    @(posedge i_ref_clk);
    o_cycle_start <= 1'b1;
    @(posedge i_ref_clk);
    o_cycle_start <= 1'b0;
    if (!hang)
    begin
      repeat (wait_cyc) @(posedge i_ref_clk);
      o_cycle_done <= 1'b1;
      @(posedge i_ref_clk);
      o_cycle_done <= 1'b0;
    end
  endtask
endmodule // bcto_bus_partner
`default_nettype wire

// ===== bench/bus_cycle_timeout_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// drives host writes and bus cycles, checks timeout timing
module bus_cycle_timeout_timer_tb_top;
  logic       i_ref_clk = 1'b0;
  logic       i_reset   = 1'b1;
  logic [7:0] i_io_addr = 8'h00;
  logic       i_io_wr_en = 1'b0;
  logic       i_io_rd_en = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic       i_sys_ctrl = 1'b1;
  logic       cyc_start, cyc_done;
  logic [7:0] o_io_rdata;
  logic       o_bus_error, o_timeout_active, o_count_loaded;
  logic [1:0] o_timer_sel;
  int         err_total, check_count, err_seen, n, s;

  // clock at 8 ns
  always #4 i_ref_clk = ~i_ref_clk;

  bcto_bus_partner bus (.i_ref_clk(i_ref_clk), .o_cycle_start(cyc_start),
    .o_cycle_done(cyc_done));
  bcto_timer dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_io_addr(i_io_addr), .i_io_wr_en(i_io_wr_en), .i_io_rd_en(i_io_rd_en),
    .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_sys_ctrl(i_sys_ctrl), .i_cycle_start(cyc_start),
    .i_cycle_done(cyc_done), .o_bus_error(o_bus_error),
    .o_timeout_active(o_timeout_active), .o_count_loaded(o_count_loaded),
    .o_timer_sel(o_timer_sel));

  // counts every error pulse seen
  always @(posedge i_ref_clk)
    if (o_bus_error === 1'b1) err_seen <= err_seen + 1;

  // cycles from start edge to error pulse
  function automatic int exp_cyc(input logic [15:0] cnt);
    return ((cnt == 16'h0000) ? 65536 : int'(cnt)) * 100 + 1;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_wr_en <= 1'b1;
    @(posedge i_ref_clk);
    i_io_wr_en <= 1'b0;
  endtask

  // setup control, then the byte pair back to back or split by a read
  task automatic load(input logic [7:0] hi, input logic [7:0] lo,
                      input bit back);
    wr(bcto_pkg::BCTO_ADDR_SETUP_CTRL, {bcto_pkg::BCTO_SEL_SYSCTL,
      bcto_pkg::BCTO_MODE_PATTERN});
    #1 chk(o_count_loaded, 1'b0);
    if (back)
    begin
      @(posedge i_ref_clk);
      i_io_addr <= bcto_pkg::BCTO_ADDR_COUNT_PORT;
      i_io_wdata <= lo;
      i_io_wr_en <= 1'b1;
      @(posedge i_ref_clk);
      i_io_wdata <= hi;
      @(posedge i_ref_clk);
      i_io_wr_en <= 1'b0;
    end
    else
    begin
      wr(bcto_pkg::BCTO_ADDR_COUNT_PORT, lo);
      i_io_rd_en <= 1'b1;
      @(posedge i_ref_clk);
      i_io_rd_en <= 1'b0;
      #1 chk(o_io_rdata, 16'h0000);
      wr(bcto_pkg::BCTO_ADDR_COUNT_PORT, hi);
    end
    @(posedge i_ref_clk);
    #1 chk(o_count_loaded, 1'b1);
  endtask

  // hung cycle: error pulse lands exactly on the expected edge
  task automatic hang(input logic [15:0] cnt);
    bus.run(0, 1'b1);
    @(posedge i_ref_clk);
    #1 chk(o_timeout_active, 1'b1);
    repeat (exp_cyc(cnt) - 3) @(posedge i_ref_clk);
    #1 chk(o_bus_error, 1'b0);
    @(posedge i_ref_clk);
    #1 chk(o_bus_error, 1'b1);
    @(posedge i_ref_clk);
    #1 chk(o_bus_error, 1'b0);
    chk(o_timeout_active, 1'b0);
  endtask

  task automatic results;
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (60000) @(posedge i_ref_clk);
    err_total++;
    results();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h4562));
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    #1 chk({o_timer_sel, o_bus_error, o_timeout_active, o_count_loaded},
      16'h0000);
    for (s = 0; s < 3; s++)
    begin
      wr(bcto_pkg::BCTO_ADDR_SETUP_CTRL, {s[1:0], 6'h34});
      @(posedge i_ref_clk);
      #1 chk(o_timer_sel, s[1:0]);
    end
    load(8'h01, 8'h02, 1'b0);
    hang(16'h0102);
    // leave controller mode mid-cycle, then start while not controller
    n = err_seen;
    load(8'h00, 8'h02, 1'b1);
    bus.run(0, 1'b1);
    repeat (50) @(posedge i_ref_clk);
    i_sys_ctrl <= 1'b0;
    bus.run(0, 1'b1);
    repeat (300) @(posedge i_ref_clk);
    #1 chk(err_seen, n);
    chk(o_timeout_active, 1'b0);
    @(posedge i_ref_clk);
    i_sys_ctrl <= 1'b1;
    // completion on the final tick edge wins over the timeout
    load(8'h00, 8'h01, 1'b1);
    s = err_seen;
    bus.run(99, 1'b0);
    repeat (10) @(posedge i_ref_clk);
    #1 chk(err_seen, s);
    repeat (6)
    begin
      n = $urandom_range(3, 1);
      load(8'h00, n[7:0], $urandom_range(1, 0) == 1);
      if ($urandom_range(1, 0) == 1)
        hang(n[15:0]);
      else
      begin
        s = err_seen;
        bus.run($urandom_range(n * 100 - 10, 5), 1'b0);
        repeat (n * 100 + 5) @(posedge i_ref_clk);
        #1 chk(err_seen, s);
        chk(o_timeout_active, 1'b0);
      end
    end
    results();
  end
endmodule // bus_cycle_timeout_timer_tb_top
`default_nettype wire
